/* File: core/sqs_pkg.sv */
// constants for the sequencer stack entries 25 to 27
// Functional notes
// - bit 15 picks direction: 0 selects reading the entry, 1 selects writing it
// - bits 14..9 hold the entry's own address; reset to that address
// - bit 8 set returns to first entry after conversion, clear steps onward except from entry 27, which always returns
// - bits 7..4 choose converter B input channel; reset to zero
// - bits 3..0 choose converter A input channel; reset to zero
// - entry 25 sits at 0x39 and reads 0x7200 after reset
// - entry 26 sits at 0x3a and reads 0x7400 after reset
// - entry 27 sits at 0x3b and reads 0x7600 after reset
package sqs_pkg;
    localparam int          SQS_ENTRIES   = 3;
    localparam int          SQS_DIR_BIT   = 15;
    localparam int          SQS_SELF_MSB  = 14;
    localparam int          SQS_SELF_LSB  = 9;
    localparam int          SQS_RET_BIT   = 8;
    localparam int          SQS_B_MSB     = 7;
    localparam int          SQS_B_LSB     = 4;
    localparam int          SQS_A_MSB     = 3;
    localparam int          SQS_A_LSB     = 0;
    // register indices; byte address is four times the index
    localparam logic [5:0]  SQS_ENTRY_IDX [SQS_ENTRIES] = '{6'h39, 6'h3a, 6'h3b};
    localparam logic [15:0] SQS_ENTRY_RST [SQS_ENTRIES] = '{16'h7200, 16'h7400, 16'h7600};
    // read-only step status register index
    localparam logic [7:0]  SQS_STATUS_IDX = 8'h40;
    localparam logic [1:0]  SQS_STEP_RST   = 2'h0;
    localparam logic [1:0]  SQS_STEP_LAST  = 2'h2;
    typedef logic [8:0] sqs_entry_t;
endpackage : sqs_pkg

/* File: core/sqs_stack_regs.sv */
// apb register bank for three sequencer stack entries plus step walker
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module sqs_stack_regs
    import sqs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    input  wire logic              i_conv_done,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    output logic [1:0]             o_step_index,
    output logic                   o_step_return,
    output logic [3:0]             o_conv_a_pick,
    output logic [3:0]             o_conv_b_pick
);

    // refuse address widths narrower than 10 bits or wider than 32
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("sqs_stack_regs: ADDR_W must be 10 to 32");
    end

    sqs_entry_t        ent_q [SQS_ENTRIES];
    sqs_entry_t        ent_d [SQS_ENTRIES];
    logic [1:0]        step_q;
    logic [1:0]        step_d;
    logic              pready_q;
    logic              pready_d;
    logic [31:0]       prdata_q;
    logic [31:0]       prdata_d;
    logic              pslverr_q;
    logic              pslverr_d;
    logic              ret_q;
    logic              ret_d;
    logic [3:0]        pick_a_q;
    logic [3:0]        pick_a_d;
    logic [3:0]        pick_b_q;
    logic [3:0]        pick_b_d;
    logic [SQS_ENTRIES-1:0] hit;
    logic [SQS_ENTRIES-1:0] wr_ok;
    logic              stat_hit;
    logic              setup;
    logic              commit;

    // full 16-bit view of an entry, self address is fixed
    function automatic logic [15:0] entry_word(input int idx, input sqs_entry_t val);
        entry_word = {1'b0, SQS_ENTRY_IDX[idx], val};
    endfunction : entry_word

    // address decode and phase detection
    always_comb begin
        setup    = i_psel && !i_penable;
        commit   = i_psel && i_penable && pready_q;
        stat_hit = (i_paddr == ADDR_W'({SQS_STATUS_IDX, 2'b00}));
        for (int i = 0; i < SQS_ENTRIES; i++) begin
            hit[i]   = (i_paddr == ADDR_W'({SQS_ENTRY_IDX[i], 2'b00}));
            wr_ok[i] = hit[i] && i_pwdata[SQS_DIR_BIT]
                       && (i_pwdata[SQS_SELF_MSB:SQS_SELF_LSB] == SQS_ENTRY_IDX[i]);
        end
    end

    // apb answer: zero wait states, data and error prepared in setup
    always_comb begin
        pready_d  = setup;
        prdata_d  = 32'h0;
        pslverr_d = 1'b0;
        if (setup) begin
            if (stat_hit) begin
                prdata_d  = {29'h0, ret_q, step_q};
                pslverr_d = i_pwrite;
            end else if (hit == '0) begin
                pslverr_d = 1'b1;
            end else begin
                for (int i = 0; i < SQS_ENTRIES; i++) begin
                    if (hit[i]) begin
                        prdata_d  = {16'h0, entry_word(i, ent_q[i])};
                        pslverr_d = i_pwrite && !wr_ok[i];
                    end
                end
            end
        end
    end

    // entry storage: only the matched entry takes the write
    always_comb begin
        for (int i = 0; i < SQS_ENTRIES; i++) begin
            ent_d[i] = ent_q[i];
            if (commit && i_pwrite && wr_ok[i]) begin
                if (i_pstrb[1]) begin
                    ent_d[i][SQS_RET_BIT] = i_pwdata[SQS_RET_BIT];
                end
                if (i_pstrb[0]) begin
                    ent_d[i][SQS_B_MSB:SQS_B_LSB] = i_pwdata[SQS_B_MSB:SQS_B_LSB];
                    ent_d[i][SQS_A_MSB:SQS_A_LSB] = i_pwdata[SQS_A_MSB:SQS_A_LSB];
                end
            end
        end
    end

    // step walker: next entry, or back to the first on return flag or after the last entry
    always_comb begin
        step_d = step_q;
        if (i_conv_done) begin
            if (ent_q[step_q][SQS_RET_BIT] || step_q == SQS_STEP_LAST) begin
                step_d = SQS_STEP_RST;
            end else begin
                step_d = step_q + 2'h1;
            end
        end
        ret_d    = ent_d[step_d][SQS_RET_BIT];
        pick_a_d = ent_d[step_d][SQS_A_MSB:SQS_A_LSB];
        pick_b_d = ent_d[step_d][SQS_B_MSB:SQS_B_LSB];
    end

    // registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < SQS_ENTRIES; i++) begin
                ent_q[i] <= SQS_ENTRY_RST[i][8:0];
            end
            step_q    <= SQS_STEP_RST;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
            ret_q     <= 1'b0;
            pick_a_q  <= 4'h0;
            pick_b_q  <= 4'h0;
        end else begin
            for (int i = 0; i < SQS_ENTRIES; i++) begin
                ent_q[i] <= ent_d[i];
            end
            step_q    <= step_d;
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            ret_q     <= ret_d;
            pick_a_q  <= pick_a_d;
            pick_b_q  <= pick_b_d;
        end
    end

    // outputs straight from flip-flops
    assign o_pready      = pready_q;
    assign o_prdata      = prdata_q;
    assign o_pslverr     = pslverr_q;
    assign o_step_index  = step_q;
    assign o_step_return = ret_q;
    assign o_conv_a_pick = pick_a_q;
    assign o_conv_b_pick = pick_b_q;

    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    logic [26:0] all_ent;
    assign all_ent = {ent_q[0], ent_q[1], ent_q[2]};

    a_entry25_reset: assert property (
        $past(i_rst) |-> entry_word(0, ent_q[0]) == 16'h7200)
        else $error("entry 25 wrong after reset");

    a_entry26_reset: assert property (
        $past(i_rst) |-> entry_word(1, ent_q[1]) == 16'h7400)
        else $error("entry 26 wrong after reset");

    a_entry27_reset: assert property (
        $past(i_rst) |-> entry_word(2, ent_q[2]) == 16'h7600)
        else $error("entry 27 wrong after reset");

    a_read_dir_keeps: assert property (
        commit && i_pwrite && !i_pwdata[SQS_DIR_BIT] |=> $stable(all_ent))
        else $error("entry changed on write with direction bit clear");

    a_self_mismatch_err: assert property (
        commit && i_pwrite && hit[0]
        && i_pwdata[SQS_SELF_MSB:SQS_SELF_LSB] != SQS_ENTRY_IDX[0]
        |-> o_pslverr ##1 $stable(ent_q[0]))
        else $error("mismatched self address not refused");

    a_write_lands: assert property (
        commit && i_pwrite && wr_ok[1] && i_pstrb[1:0] == 2'b11
        |=> ent_q[1] == $past(i_pwdata[8:0]))
        else $error("write to entry 26 did not land");

    a_write_isolated: assert property (
        commit && i_pwrite && wr_ok[0] |=> $stable(ent_q[1]) && $stable(ent_q[2]))
        else $error("write to entry 25 disturbed others");

    a_read_word: assert property (
        commit && !i_pwrite && hit[2] |-> o_prdata == {16'h0, entry_word(2, ent_q[2])}
        && !o_pslverr)
        else $error("entry 27 read data wrong");

    a_return_first: assert property (
        i_conv_done && ent_q[step_q][SQS_RET_BIT] |=> step_q == 2'h0)
        else $error("return flag did not send walker to first entry");

    a_advance_next: assert property (
        i_conv_done && !ent_q[step_q][SQS_RET_BIT] && step_q < SQS_STEP_LAST
        |=> step_q == $past(step_q) + 2'h1)
        else $error("walker did not advance");

    a_pick_b_follow: assert property (
        $past(!i_rst) |-> o_conv_b_pick == ent_q[step_q][SQS_B_MSB:SQS_B_LSB])
        else $error("converter b pick off its entry");

    a_pick_a_follow: assert property (
        $past(!i_rst) |-> o_conv_a_pick == ent_q[step_q][SQS_A_MSB:SQS_A_LSB])
        else $error("converter a pick off its entry");

    // bus answer shape: one-cycle ready, quiet data outside it
    a_ready_pulse: assert property (
        o_pready
        |=> !o_pready)
        else $error("ready stood longer than one cycle");

    a_idle_rdata_zero: assert property (
        !o_pready
        |-> o_prdata == 32'h0)
        else $error("read data not zero outside ready");

    a_upper_zero: assert property (
        o_pready
        |-> o_prdata[31:16] == 16'h0)
        else $error("upper read data bits not zero");

    a_setup_ready: assert property (
        setup
        |=> o_pready)
        else $error("no ready after setup");

    a_idle_no_ready: assert property (
        !i_psel
        |=> !o_pready)
        else $error("ready without a selected transfer");

    a_read_no_err: assert property (
        setup && !i_pwrite && hit != '0
        |=> !o_pslverr)
        else $error("read of a mapped entry flagged an error");

    // refused accesses: error flag and untouched storage
    a_unmapped_err: assert property (
        setup && hit == '0 && !stat_hit
        |=> o_pready && o_pslverr)
        else $error("unmapped address not refused");

    a_status_write_err: assert property (
        setup && stat_hit && i_pwrite
        |=> o_pslverr)
        else $error("write to status not refused");

    a_status_write_keep: assert property (
        commit && i_pwrite && stat_hit
        |=> $stable(all_ent))
        else $error("status write changed an entry");

    a_dir_clear_err: assert property (
        setup && i_pwrite && hit[0] && !i_pwdata[SQS_DIR_BIT]
        |=> o_pslverr)
        else $error("write with direction bit clear not refused");

    // write landing, strobe lanes and isolation
    a_entry25_lands: assert property (
        commit && i_pwrite && wr_ok[0] && i_pstrb[1:0] == 2'b11
        |=> ent_q[0] == $past(i_pwdata[8:0]))
        else $error("write to entry 25 did not land");

    a_entry27_isolated: assert property (
        commit && i_pwrite && wr_ok[2]
        |=> $stable(ent_q[0]) && $stable(ent_q[1]))
        else $error("write to entry 27 disturbed others");

    a_ret_strobe_hold: assert property (
        commit && i_pwrite && wr_ok[0] && !i_pstrb[1]
        |=> $stable(ent_q[0][SQS_RET_BIT]))
        else $error("return flag changed without its strobe");

    a_pick_strobe_hold: assert property (
        commit && i_pwrite && wr_ok[0] && !i_pstrb[0]
        |=> $stable(ent_q[0][SQS_B_MSB:SQS_A_LSB]))
        else $error("channel picks changed without their strobe");

    // walker bounds and holding
    a_wrap_last: assert property (
        i_conv_done && step_q == SQS_STEP_LAST
        |=> step_q == SQS_STEP_RST)
        else $error("walker did not wrap after last entry");

    a_step_hold: assert property (
        !i_conv_done
        |=> $stable(step_q))
        else $error("walker moved without a conversion");

    a_step_range: assert property (
        1'b1
        |-> step_q <= SQS_STEP_LAST)
        else $error("walker step out of range");

    a_return_follow: assert property (
        $past(!i_rst)
        |-> o_step_return == ent_q[step_q][SQS_RET_BIT])
        else $error("return output off its entry");

endmodule : sqs_stack_regs

/* File: testbench/sqs_conv_model.sv */
// conversion engine stand-in: one done pulse per fire request
`timescale 1ns/1ps
module sqs_conv_model (
    input  wire logic i_clk_sys,
    input  wire logic i_fire,
    output logic      o_conv_done
);
    // registered pulse on the same clock as the register bank
    always_ff @(posedge i_clk_sys) begin
        o_conv_done <= i_fire;
    end
endmodule : sqs_conv_model

/* File: testbench/testbench.sv */
// self-checking bench for the sequencer stack register bank
`timescale 1ns/1ps
module testbench;
    import sqs_pkg::*;
    logic        clk, rst, psel, penable, pwrite, fire, done;
    logic        pready, pslverr, ret;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, pa, pb;
    logic [1:0]  step;
    int          errors = 0;
    int          n_tests = 0;
    int          cyc = 0;

    sqs_stack_regs i_dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_conv_done(done), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .o_step_index(step), .o_step_return(ret), .o_conv_a_pick(pa), .o_conv_b_pick(pb));

    sqs_conv_model i_conv (.i_clk_sys(clk), .i_fire(fire), .o_conv_done(done));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // verdict and end of run
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk

    // one apb transfer; error flag and read data compared at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic xe, input logic [31:0] xr);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        chk({31'h0, pslverr}, {31'h0, xe});
        if (!w && !xe) chk(prdata, xr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one conversion done, then step and picks compared
    task automatic pulse(input logic [10:0] x);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
        chk({21'h0, step, ret, pb, pa}, {21'h0, x});
    endtask : pulse

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        fire = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < SQS_ENTRIES; i++)
            apb(0, {4'h0, SQS_ENTRY_IDX[i], 2'h0}, 0, 0, 32'(SQS_ENTRY_RST[i]));
        apb(1, 12'he8, 32'h0000f5a3, 0, 0);
        apb(0, 12'he8, 0, 0, 32'h000075a3);
        apb(0, 12'he4, 0, 0, 32'h00007200);
        apb(0, 12'hec, 0, 0, 32'h00007600);
        apb(1, 12'he4, 32'h00007221, 1, 0);
        apb(1, 12'he4, 32'h0000f421, 1, 0);
        apb(0, 12'h0f0, 0, 1, 0);
        apb(0, 12'he4, 0, 0, 32'h00007200);
        apb(1, 12'he4, 32'h0000f221, 0, 0);
        @(posedge clk);
        chk({21'h0, step, ret, pb, pa}, 32'h021);
        pulse(11'h3a3);
        apb(0, 12'h100, 0, 0, 32'h00000005);
        apb(1, 12'h100, 32'h0, 1, 0);
        pulse(11'h021);
        apb(1, 12'he8, 32'h0000f4c7, 0, 0);
        pulse(11'h2c7);
        pulse(11'h400);
        pulse(11'h021);
        apb(1, 12'hec, 32'h0000f75a, 0, 0);
        apb(0, 12'hec, 0, 0, 32'h0000775a);
        pstrb <= 4'h2;
        apb(1, 12'he4, 32'h0000f3ff, 0, 0);
        pstrb <= 4'h1;
        apb(1, 12'he4, 32'h0000f2ff, 0, 0);
        pstrb <= 4'hf;
        apb(0, 12'he4, 0, 0, 32'h000073ff);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({21'h0, step, ret, pb, pa}, 32'h0);
        apb(0, 12'he4, 0, 0, 32'h00007200);
        complete_run();
    end
endmodule : testbench
